// *** unmp_pkg.sv ***
// unmp_pkg: constants shared by the nine-bit multiprocessor serial port and its transmit queue.
// assumes a 16x oversampling baud tick supplied by a rate generator outside the block.
`default_nettype none

package unmp_pkg;

    // serial_control_reg field positions
    localparam int CTL_RX_DONE   = 0;
    localparam int CTL_TX_DONE   = 1;
    localparam int CTL_RX_NINTH  = 2;
    localparam int CTL_TX_NINTH  = 3;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_MULTIPROC = 5;
    localparam int CTL_MODE_9BIT = 7;

    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    localparam int DATA_W     = 8;
    localparam int TXQ_DEPTH  = 32;

    // bit timing in baud ticks, and the index of the last data bit
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [2:0] LAST_BIT = 3'h7;

endpackage

`default_nettype wire

// *** unmp_fifo.sv ***
// unmp_fifo: flip-flop queue with valid/ready on both sides.
// assumes one clock and a synchronous active-low reset; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none

module unmp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i,
    output var  logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             in_ready_ff;
    logic             out_valid_ff;
    wire              push = in_valid_i & in_ready_ff;
    wire              pop  = out_valid_ff & out_ready_i;
    wire  [AW:0]      nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign in_ready_o  = in_ready_ff;
    assign out_valid_o = out_valid_ff;
    assign out_data_o  = mem_ff[rd_ptr_ff];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // ready and valid are registered so the fill level never leaks a combinational path
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            in_ready_ff  <= 1'b0;
            out_valid_ff <= 1'b0;
        end else begin
            wr_ptr_ff    <= wr_ptr_ff + AW'(push);
            rd_ptr_ff    <= rd_ptr_ff + AW'(pop);
            count_ff     <= nxt_count;
            in_ready_ff  <= (nxt_count != FULL_CNT);
            out_valid_ff <= (nxt_count != '0);
        end
    end

endmodule

`default_nettype wire

// *** unmp_uart.sv ***
// unmp_uart: full-duplex serial port with 8-bit and 9-bit framing and address filtering.
// assumes baud_tick_i pulses at 16x the bit rate and all inputs are synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module unmp_uart (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       baud_tick_i,
    input  wire logic       data_we_i,
    input  wire logic [7:0] data_wdata_i,
    output var  logic       data_ready_o,
    input  wire logic       ctrl_we_i,
    input  wire logic [7:0] ctrl_wdata_i,
    input  wire logic       int_enable_i,
    input  wire logic       rx_line_i,
    output var  logic       tx_line_o,
    output var  logic [7:0] serial_control_reg_o,
    output var  logic [7:0] serial_data_buffer_o,
    output var  logic       irq_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} unmp_state_e;

    // control bits
    logic mode_9bit_ff, multiproc_enable_ff, rx_enable_bit_ff;
    logic tx_ninth_bit_ff, rx_ninth_bit_ff, tx_done_flag_ff, rx_done_flag_ff;
    logic irq_ff;
    logic [7:0] rx_buf_ff;

    // transmit queue
    logic       q_valid;
    logic [7:0] q_data;
    logic       q_pop;

    unmp_fifo #(
        .WIDTH (unmp_pkg::DATA_W),
        .DEPTH (unmp_pkg::TXQ_DEPTH)
    ) u_txq (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (data_we_i),
        .in_ready_o  (data_ready_o),
        .in_data_i   (data_wdata_i),
        .out_valid_o (q_valid),
        .out_ready_i (q_pop),
        .out_data_o  (q_data)
    );

    // transmitter
    unmp_state_e tx_state_ff, nxt_tx_state;
    logic [3:0]  tx_tick_ff;
    logic [2:0]  tx_idx_ff, nxt_tx_idx;
    logic [7:0]  tx_shift_ff, nxt_tx_shift;
    logic        tx_line_ff, nxt_tx_line;
    logic        tx_set_done;

    wire tx_bit_end = baud_tick_i & (tx_tick_ff == unmp_pkg::OVS_LAST);
    wire tx_last    = (tx_idx_ff == unmp_pkg::LAST_BIT);

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_idx   = tx_idx_ff;
        nxt_tx_shift = tx_shift_ff;
        tx_set_done  = 1'b0;
        q_pop        = 1'b0;
        case (tx_state_ff)
            ST_IDLE: begin
                if (q_valid) begin
                    q_pop        = 1'b1;
                    nxt_tx_shift = q_data;
                    nxt_tx_state = ST_START;
                end
            end
            ST_START: begin
                if (tx_bit_end) begin
                    nxt_tx_idx   = '0;
                    nxt_tx_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (tx_bit_end) begin
                    nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
                    nxt_tx_idx   = tx_idx_ff + 3'h1;
                    if (tx_last) begin
                        nxt_tx_state = mode_9bit_ff ? ST_NINTH : ST_STOP;
                        tx_set_done  = !mode_9bit_ff;
                    end
                end
            end
            ST_NINTH: begin
                if (tx_bit_end) begin
                    nxt_tx_state = ST_STOP;
                    tx_set_done  = 1'b1;
                end
            end
            ST_STOP: begin
                if (tx_bit_end) begin
                    nxt_tx_state = ST_IDLE;
                end
            end
            default: nxt_tx_state = ST_IDLE;
        endcase
        case (nxt_tx_state)
            ST_START: nxt_tx_line = 1'b0;
            ST_DATA:  nxt_tx_line = nxt_tx_shift[0];
            ST_NINTH: nxt_tx_line = tx_ninth_bit_ff;
            default:  nxt_tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            tx_state_ff <= ST_IDLE;
            tx_tick_ff  <= '0;
            tx_idx_ff   <= '0;
            tx_shift_ff <= unmp_pkg::DATA_RESET;
            tx_line_ff  <= 1'b1;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tx_tick_ff  <= (tx_state_ff == ST_IDLE) ? 4'h0 : tx_tick_ff + 4'(baud_tick_i);
            tx_idx_ff   <= nxt_tx_idx;
            tx_shift_ff <= nxt_tx_shift;
            tx_line_ff  <= nxt_tx_line;
        end
    end

    // receiver
    unmp_state_e rx_state_ff, nxt_rx_state;
    logic [3:0]  rx_tick_ff;
    logic [2:0]  rx_idx_ff, nxt_rx_idx;
    logic [7:0]  rx_shift_ff, nxt_rx_shift;
    logic        rx_ninth_ff, nxt_rx_ninth;
    logic        rx_prev_ff;

    // the tick counter starts at the edge, so each sample lands mid-bit
    wire rx_sample  = baud_tick_i & (rx_tick_ff == unmp_pkg::OVS_MID);
    wire rx_fall    = rx_prev_ff & !rx_line_i;
    wire rx_end     = rx_sample & (rx_state_ff == ST_STOP);
    // in 8-bit mode the stop bit stands in the ninth-bit field, as on the classic port
    wire rx_frame9  = mode_9bit_ff ? rx_ninth_ff : rx_line_i;
    wire rx_accept  = rx_end & !rx_done_flag_ff
                      & (!(multiproc_enable_ff & mode_9bit_ff) | rx_ninth_ff);

    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_idx   = rx_idx_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_rx_ninth = rx_ninth_ff;
        case (rx_state_ff)
            ST_IDLE: begin
                if (rx_enable_bit_ff && rx_fall) begin
                    nxt_rx_state = ST_START;
                end
            end
            ST_START: begin
                if (rx_sample) begin
                    nxt_rx_idx   = '0;
                    nxt_rx_state = rx_line_i ? ST_IDLE : ST_DATA;   // glitch rejected
                end
            end
            ST_DATA: begin
                if (rx_sample) begin
                    nxt_rx_shift = {rx_line_i, rx_shift_ff[7:1]};
                    nxt_rx_idx   = rx_idx_ff + 3'h1;
                    if (rx_idx_ff == unmp_pkg::LAST_BIT) begin
                        nxt_rx_state = mode_9bit_ff ? ST_NINTH : ST_STOP;
                    end
                end
            end
            ST_NINTH: begin
                if (rx_sample) begin
                    nxt_rx_ninth = rx_line_i;
                    nxt_rx_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (rx_sample) begin
                    nxt_rx_state = ST_IDLE;   // stop value not checked
                end
            end
            default: nxt_rx_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rx_state_ff <= ST_IDLE;
            rx_tick_ff  <= '0;
            rx_idx_ff   <= '0;
            rx_shift_ff <= unmp_pkg::DATA_RESET;
            rx_ninth_ff <= 1'b0;
            rx_prev_ff  <= 1'b1;
        end else begin
            rx_state_ff <= nxt_rx_state;
            rx_tick_ff  <= (rx_state_ff == ST_IDLE) ? 4'h0 : rx_tick_ff + 4'(baud_tick_i);
            rx_idx_ff   <= nxt_rx_idx;
            rx_shift_ff <= nxt_rx_shift;
            rx_ninth_ff <= nxt_rx_ninth;
            rx_prev_ff  <= rx_line_i;
        end
    end

    // control register: hardware set wins over a software write of 0
    wire nxt_tx_done = tx_set_done | (ctrl_we_i ? ctrl_wdata_i[unmp_pkg::CTL_TX_DONE] : tx_done_flag_ff);
    wire nxt_rx_done = rx_accept | (ctrl_we_i ? ctrl_wdata_i[unmp_pkg::CTL_RX_DONE] : rx_done_flag_ff);

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mode_9bit_ff        <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_MODE_9BIT];
            multiproc_enable_ff <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_MULTIPROC];
            rx_enable_bit_ff    <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_RX_ENABLE];
            tx_ninth_bit_ff     <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_TX_NINTH];
            rx_ninth_bit_ff     <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_RX_NINTH];
            tx_done_flag_ff     <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_TX_DONE];
            rx_done_flag_ff     <= unmp_pkg::CTL_RESET[unmp_pkg::CTL_RX_DONE];
            rx_buf_ff           <= unmp_pkg::DATA_RESET;
            irq_ff              <= 1'b0;
        end else begin
            if (ctrl_we_i) begin
                mode_9bit_ff        <= ctrl_wdata_i[unmp_pkg::CTL_MODE_9BIT];
                multiproc_enable_ff <= ctrl_wdata_i[unmp_pkg::CTL_MULTIPROC];
                rx_enable_bit_ff    <= ctrl_wdata_i[unmp_pkg::CTL_RX_ENABLE];
                tx_ninth_bit_ff     <= ctrl_wdata_i[unmp_pkg::CTL_TX_NINTH];
            end
            if (rx_accept) begin
                rx_buf_ff       <= rx_shift_ff;
                rx_ninth_bit_ff <= rx_frame9;
            end else if (ctrl_we_i) begin
                rx_ninth_bit_ff <= ctrl_wdata_i[unmp_pkg::CTL_RX_NINTH];
            end
            tx_done_flag_ff <= nxt_tx_done;
            rx_done_flag_ff <= nxt_rx_done;
            irq_ff          <= int_enable_i & (nxt_tx_done | nxt_rx_done);
        end
    end

    assign tx_line_o            = tx_line_ff;
    assign irq_o                = irq_ff;
    assign serial_data_buffer_o = rx_buf_ff;   // transmit side never readable
    assign serial_control_reg_o = {mode_9bit_ff, 1'b0, multiproc_enable_ff, rx_enable_bit_ff,
                                   tx_ninth_bit_ff, rx_ninth_bit_ff, tx_done_flag_ff, rx_done_flag_ff};

    // checks
    AST_IRQ_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ##1 ($past(int_enable_i) & (tx_done_flag_ff | rx_done_flag_ff)) |-> irq_o)
        else $error("interrupt missing while a done flag is set");
    AST_TX_DONE_AT_STOP: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tx_state_ff != ST_STOP) ##1 (tx_state_ff == ST_STOP) |-> tx_done_flag_ff)
        else $error("tx done not set as stop bit starts");
    AST_STOP_LINE_HIGH: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tx_state_ff == ST_STOP) |-> tx_line_o)
        else $error("stop bit not high");
    AST_START_LINE_LOW: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tx_state_ff == ST_START) |-> !tx_line_o)
        else $error("start bit not low");
    AST_NINTH_FROM_CTRL: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(tx_state_ff == ST_NINTH) |-> tx_line_o == $past(tx_ninth_bit_ff))
        else $error("ninth bit does not follow control");
    AST_REFUSE_KEEPS_BUF: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_end & rx_done_flag_ff) |=> $stable(serial_data_buffer_o))
        else $error("buffer overwritten while receive done set");
    AST_ACCEPT_LOADS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        rx_accept |=> rx_done_flag_ff && serial_data_buffer_o == $past(rx_shift_ff))
        else $error("accepted character not loaded");
    AST_MCE_FILTER: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_end & multiproc_enable_ff & mode_9bit_ff & !rx_ninth_ff) |=> !$rose(rx_done_flag_ff))
        else $error("data character flagged under multiprocessor filter");
    AST_RX_NEEDS_EN: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_state_ff == ST_IDLE && !rx_enable_bit_ff) |=> rx_state_ff == ST_IDLE)
        else $error("reception started while disabled");
    AST_FLAG_STICKY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tx_done_flag_ff && !ctrl_we_i) |=> tx_done_flag_ff)
        else $error("tx done cleared without software");
    AST_RX_FLAG_STICKY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_done_flag_ff && !ctrl_we_i) |=> rx_done_flag_ff)
        else $error("rx done cleared without software");
    AST_IRQ_NEEDS_FLAG: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        irq_o |-> (tx_done_flag_ff | rx_done_flag_ff))
        else $error("interrupt raised with no done flag set");

    COV_TX_NINE: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        tx_state_ff == ST_NINTH ##1 tx_state_ff == ST_STOP);
    COV_RX_ACCEPT: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) rx_accept);
    COV_RX_REFUSE: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) rx_end & !rx_accept);
    COV_QUEUE_FULL: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) !data_ready_o);

endmodule

`default_nettype wire

// *** unmp_remote.sv ***
// unmp_remote: far-end serial transceiver model for the nine-bit serial port bench.
// assumes the bench baud tick is shared and 16 ticks make one bit time.
`timescale 1ns/1ps
`default_nettype none
module unmp_remote (
    input  wire logic sys_clk_i,
    input  wire logic baud_tick_i,
    input  wire logic nine_i,
    input  wire logic line_i,
    output var  logic line_o
);
    logic [8:0] got_q[$];
    initial line_o = 1'b1;
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            while (baud_tick_i !== 1'b1) @(posedge sys_clk_i);
        end
    endtask
    // line is back high after the stop bit, as a pulled-up idle line would be
    task automatic send(input logic [7:0] d, input logic nb, input logic nine);
        logic [10:0] f;
        f = {1'b1, nine ? nb : 1'b1, d, 1'b0};
        // align to an edge so every bit change keeps the bench's drive delay
        @(posedge sys_clk_i);
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            #2 line_o = f[i];
            ticks(16);
        end
    endtask
    // ninth slot holds the stop bit in 8-bit framing
    initial forever begin : rx_side
        logic [8:0] v;
        @(negedge line_i);
        ticks(8);
        for (int i = 0; i < 9; i++) begin
            ticks(16);
            v[i] = line_i;
        end
        got_q.push_back(v);
        if (nine_i) ticks(16);
    end
endmodule
`default_nettype wire

// *** test_uart_nine_bit_multiproc.sv ***
// test_uart_nine_bit_multiproc: self-checking bench for the nine-bit serial port.
// assumes unmp_pkg, unmp_fifo, unmp_uart and unmp_remote are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_uart_nine_bit_multiproc;
    localparam int DLY   = 2;
    localparam int LIMIT = 40000;
    logic       sys_clk_i    = 1'b0;
    logic       resetn_i     = 1'b0;
    logic       baud_tick_i  = 1'b0;
    logic       data_we_i    = 1'b0;
    logic [7:0] data_wdata_i = 8'h00;
    logic       ctrl_we_i    = 1'b0;
    logic [7:0] ctrl_wdata_i = 8'h00;
    logic       int_enable_i = 1'b1;
    logic       rx_line, tx_line, data_ready, irq;
    logic [7:0] ctl, dbuf;
    logic [7:0] lfsr_ff = 8'h42;
    logic [7:0] ctl_sw  = 8'h00;
    logic [7:0] m_buf   = 8'h00;
    logic       m_nb    = 1'b0;
    logic       m_rxd   = 1'b0;
    logic [7:0] exp_q[$];
    int         n_fail = 0;
    int         n_checks = 0;
    int         cyc = 0;

    unmp_uart dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .baud_tick_i(baud_tick_i), .data_we_i(data_we_i),
        .data_wdata_i(data_wdata_i), .data_ready_o(data_ready), .ctrl_we_i(ctrl_we_i), .ctrl_wdata_i(ctrl_wdata_i),
        .int_enable_i(int_enable_i), .rx_line_i(rx_line), .tx_line_o(tx_line), .serial_control_reg_o(ctl),
        .serial_data_buffer_o(dbuf), .irq_o(irq));
    unmp_remote far (.sys_clk_i(sys_clk_i), .baud_tick_i(baud_tick_i), .nine_i(ctl_sw[7]), .line_i(tx_line),
        .line_o(rx_line));

    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    // tick every other cycle makes a bit 32 cycles, so a frame is 320 cycles, or 352 with a ninth bit
    always @(posedge sys_clk_i) baud_tick_i <= #DLY ~baud_tick_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    function automatic logic [7:0] rnd();
        lfsr_ff = {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
        return lfsr_ff;
    endfunction
    task automatic cmp_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_flag(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #DLY;
    endtask
    task automatic ctrl_wr(input logic [7:0] v);
        ctl_sw = v;
        m_rxd = v[0];
        m_nb = v[2];
        ctrl_we_i = 1'b1;
        ctrl_wdata_i = v;
        step(1);
        ctrl_we_i = 1'b0;
        step(1);
    endtask
    task automatic wait_flag(input int idx, input int lim);
        int k;
        k = 0;
        while (ctl[idx] !== 1'b1 && k < lim) begin
            step(1);
            k++;
        end
        cmp_flag("done flag", 1'b1, ctl[idx]);
    endtask
    task automatic test_tx(input logic [7:0] mode, input int lim);
        int k;
        logic nb;
        nb = mode[7] ? mode[3] : 1'b1;
        ctrl_wr(mode);
        k = 0;
        while (data_ready === 1'b1 && k < lim) begin
            data_wdata_i = rnd();
            data_we_i = 1'b1;
            exp_q.push_back(data_wdata_i);
            step(1);
            k++;
        end
        // only a full queue gets the extra byte, which it must drop
        data_wdata_i = rnd();
        data_we_i = ~data_ready;
        step(1);
        data_we_i = 1'b0;
        // full queue plus the one byte the idle transmitter took at once
        cmp_val("writes taken", (lim < 40) ? 9'(lim) : 9'(unmp_pkg::TXQ_DEPTH + 1), 9'(k));
        k = 0;
        while (far.got_q.size() < exp_q.size() && k < 20000) begin
            step(1);
            k++;
        end
        while (exp_q.size() > 0 && far.got_q.size() > 0)
            cmp_val("tx frame", {nb, exp_q.pop_front()}, far.got_q.pop_front());
        cmp_val("frames left", 9'h000, 9'(exp_q.size() + far.got_q.size()));
        wait_flag(unmp_pkg::CTL_TX_DONE, 200);
        step(20);
        cmp_flag("tx done held", 1'b1, ctl[1]);
        cmp_flag("irq tx", 1'b1, irq);
        ctrl_wr(mode);
        cmp_flag("tx done cleared", 1'b0, ctl[1]);
        cmp_flag("irq clear", 1'b0, irq);
        $display("test tx mode %h done", mode);
    endtask
    task automatic rx_one(input logic [7:0] d, input logic nb);
        logic take;
        far.send(d, nb, ctl_sw[7]);
        take = ctl_sw[4] && !m_rxd && (!ctl_sw[7] || !ctl_sw[5] || nb);
        if (take) begin
            m_buf = d;
            m_nb = ctl_sw[7] ? nb : 1'b1;
            m_rxd = 1'b1;
        end
        step(2);
        cmp_val("rx buffer", {1'b0, m_buf}, {1'b0, dbuf});
        cmp_flag("rx ninth", m_nb, ctl[2]);
        cmp_flag("rx done", m_rxd, ctl[0]);
        cmp_flag("irq rx", m_rxd & int_enable_i, irq);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        step(20);
        resetn_i = 1'b1;
        step(2);
        cmp_flag("line idle", 1'b1, tx_line);
        cmp_val("control reset", {1'b0, unmp_pkg::CTL_RESET}, {1'b0, ctl});
        cmp_val("buffer reset", {1'b0, unmp_pkg::DATA_RESET}, {1'b0, dbuf});
        cmp_flag("irq reset", 1'b0, irq);
        $display("test reset done");
        test_tx(8'h00, 40);
        test_tx(8'h88, 3);
        test_tx(8'h80, 3);
        rx_one(rnd(), 1'b1);
        ctrl_wr(8'h10);
        rx_one(rnd(), 1'b1);
        rx_one(rnd(), 1'b1);
        int_enable_i = 1'b0;
        step(2);
        cmp_flag("irq masked", 1'b0, irq);
        int_enable_i = 1'b1;
        ctrl_wr(8'h30);
        rx_one(rnd(), 1'b0);
        ctrl_wr(8'hb0);
        rx_one(rnd(), 1'b0);
        rx_one(rnd(), 1'b1);
        ctrl_wr(8'h90);
        rx_one(rnd(), 1'b0);
        ctrl_wr(8'h90);
        fork
            begin
                far.send(8'h5a, 1'b1, 1'b1);
                far.send(8'ha5, 1'b0, 1'b1);
            end
            begin
                wait_flag(unmp_pkg::CTL_RX_DONE, 2000);
                cmp_val("first byte", 9'h05a, {1'b0, dbuf});
                ctrl_wr(8'h90);
                wait_flag(unmp_pkg::CTL_RX_DONE, 2000);
                cmp_val("second byte", 9'h0a5, {1'b0, dbuf});
                cmp_flag("second ninth", 1'b0, ctl[2]);
            end
        join
        ctrl_wr(8'h03);
        cmp_val("sw set flags", 9'h003, {1'b0, ctl});
        cmp_flag("irq sw set", 1'b1, irq);
        $display("test receive done");
        report_and_stop();
    end
endmodule
`default_nettype wire
